// ---- design/icc_device.sv ----
// Converter end: pointer decode, DAC load, ADC sequencer, GPIO pins.
// Assumes the host runs scl freely and frames transfers with frame_n.
// Functional notes
// - Load mode 00: input copies to DAC
// - Load mode 01: input registers only
// - Mode 10 loads all, then reverts 01
// - Host reads DAC input regs in any sequencer state
// - DAC readback pointer low bits pick channel
// - DAC word: flag 1, channel, value
// - Host configures ADC pins before converting
// - Sequence write starts first selected channel
// - Selected channels convert in ascending order
// - Convert on ack rise before MSB
// - Repeat restarts; else last result held
// - ADC word: flag 0, channel, result
// - New sequence drops old remaining channels
// - All-clear sequence write stops sequencing
// - Output config bit makes channel output
// - Push-pull pin follows output data
// - Open drain: low drives, high floats
// - Data bits of non-outputs are ignored
// - Input config bit makes channel input
// - GPIO readback returns input pin levels
// - Three-state bit floats the pin
// - Pull-down bit enables pin pull-down
// - Mode 0 pointer selects control register
// - DAC write fills channel input register
`timescale 1ns/10ps
module icc_device
   import icc_pkg::*;
(
   input wire logic rstn,
   icc_link_if.dev link,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic [7:0] io_oe,
   output logic [7:0] io_pulldown,
   output logic [95:0] dac_value,
   input wire logic [11:0] adc_sample,
   output logic [2:0] adc_channel
);
   // ----------------------------------------
   // Sequence search
   // ----------------------------------------
   function automatic logic [3:0] icc_next_ch(input logic [7:0] mask, input logic [3:0] from);
      logic [3:0] res;
      res = 4'h0;
      for (int i = CH_N - 1; i >= 0; i--)
         if (mask[i] && (4'(i) >= from))
            res = {1'b1, 3'(i)};
      return res;
   endfunction

   // ----------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------
   logic rst_s1_q, rst_s2_q;
   logic [19:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
   wire rst_n = rst_s2_q;

   always_ff @(posedge link.scl)
   begin
      rst_s1_q <= rstn;
      rst_s2_q <= rst_s1_q;
      pin_s1_q <= {adc_sample, io_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
   end

   // Each bit moves once two stages agree
   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
         pin_q <= 20'h00000;
      else
         pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
   end

   wire [7:0] gpio_in_s = pin_q[7:0];
   wire [11:0] adc_s = pin_q[19:8];

   // ----------------------------------------
   // Bit and byte framing
   // ----------------------------------------
   logic [3:0] bit_q;
   logic [2:0] byte_q;
   logic par_q, rd_q, sda_oe_q;
   logic [7:0] shift_q, ptr_q, msb_q;
   logic [15:0] tx_q;

   wire in_frame = !link.frame_n;
   wire data_slot = bit_q < ACK_SLOT;
   wire ack_slot = bit_q == ACK_SLOT;
   wire [7:0] rx_byte = {shift_q[6:0], link.sda_line};
   wire byte_done = in_frame && bit_q == LAST_BIT;
   wire ctrl_done = byte_done && byte_q == BYTE_CTRL;
   wire ptr_done = byte_done && !rd_q && byte_q == BYTE_PTR;
   wire wr_exec = byte_done && !rd_q && byte_q == BYTE_LSB;
   // Next word only when the line shows an ack, not a nack
   wire load_tx = in_frame && rd_q && ack_slot && par_q && !link.sda_line;
   wire [15:0] wd = {msb_q, rx_byte};
   wire [3:0] mode = ptr_q[7:4];
   wire [3:0] idx = ptr_q[3:0];
   wire cfg_wr = wr_exec && mode == MODE_CFG;
   wire we_seq = cfg_wr && idx == REG_ADC_SEQ;
   wire we_pd = cfg_wr && idx == REG_PULLDOWN;
   wire we_load = cfg_wr && idx == REG_LOAD_MODE;
   wire we_ocfg = cfg_wr && idx == REG_GPIO_OUT_CFG;
   wire we_odat = cfg_wr && idx == REG_GPIO_OUT_DATA;
   wire we_icfg = cfg_wr && idx == REG_GPIO_IN_CFG;
   wire we_od = cfg_wr && idx == REG_OPEN_DRAIN;
   wire we_ts = cfg_wr && idx == REG_THREE_STATE;
   wire dac_wr = wr_exec && mode == MODE_DAC_WR;
   wire adc_rd = mode == MODE_ADC_RD;

   always_ff @(posedge link.scl)
   begin
      if (!rst_n || !in_frame)
      begin
         bit_q <= 4'h0;
         byte_q <= BYTE_CTRL;
         par_q <= 1'b0;
         rd_q <= 1'b0;
         shift_q <= 8'h00;
      end
      else
      begin
         bit_q <= ack_slot ? 4'h0 : bit_q + 4'h1;
         if (data_slot)
            shift_q <= rx_byte;
         if (byte_done)
            par_q <= !par_q;
         if (byte_done && byte_q != BYTE_SAT)
            byte_q <= byte_q + 3'h1;
         if (ctrl_done)
            rd_q <= rx_byte[0];
      end
   end

   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
      begin
         ptr_q <= 8'h00;
         msb_q <= 8'h00;
      end
      else
      begin
         if (ptr_done)
            ptr_q <= rx_byte;
         if (byte_done)
            msb_q <= rx_byte;
      end
   end

   // Device pulls low for its acks and for zero bits it sends
   wire dev_ack = ack_slot && byte_q != BYTE_CTRL && (!rd_q || byte_q == BYTE_PTR);
   wire dev_tx = data_slot && rd_q && byte_q != BYTE_CTRL && !tx_q[15];
   wire drive_low = in_frame && (dev_ack || dev_tx);

   always_ff @(negedge link.scl)
   begin
      if (!rst_n)
         sda_oe_q <= 1'b0;
      else
         sda_oe_q <= drive_low;
   end

   assign link.dev_sda_out = 1'b0;
   // Line let go as soon as the frame ends
   assign link.dev_sda_oe = sda_oe_q && in_frame;

   // ----------------------------------------
   // DAC registers
   // ----------------------------------------
   logic [11:0] dac_in_q [CH_N];
   logic [11:0] dac_reg_q [CH_N];
   logic [1:0] load_mode_q;
   wire [2:0] dac_ch = idx[2:0];

   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
      begin
         load_mode_q <= LOAD_RST;
         for (int i = 0; i < CH_N; i++)
         begin
            dac_in_q[i] <= 12'h000;
            dac_reg_q[i] <= 12'h000;
         end
      end
      else
      begin
         if (dac_wr)
            dac_in_q[dac_ch] <= wd[11:0];
         if (dac_wr && load_mode_q == LOAD_AUTO)
            dac_reg_q[dac_ch] <= wd[11:0];
         if (we_load && wd[1:0] == LOAD_PULSE)
         begin
            for (int i = 0; i < CH_N; i++)
               dac_reg_q[i] <= dac_in_q[i];
            load_mode_q <= LOAD_HOLD;
         end
         else if (we_load)
            load_mode_q <= wd[1:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < CH_N; g++)
      begin : g_dac
         assign dac_value[g * DAC_W +: DAC_W] = dac_reg_q[g];
      end
   endgenerate

   // ----------------------------------------
   // ADC sequencer
   // ----------------------------------------
   logic [7:0] seq_q;
   logic rep_q, temp_q, active_q;
   logic [2:0] cur_q;
   logic [15:0] last_q;
   wire [3:0] first_new = icc_next_ch(wd[7:0], 4'h0);
   wire [3:0] first_old = icc_next_ch(seq_q, 4'h0);
   wire [3:0] next_old = icc_next_ch(seq_q, {1'b0, cur_q} + 4'h1);
   wire [15:0] adc_word = {RB_ADC_FLAG, cur_q, adc_s};
   wire convert = load_tx && adc_rd && active_q;

   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
      begin
         seq_q <= 8'h00;
         rep_q <= 1'b0;
         temp_q <= 1'b0;
         active_q <= 1'b0;
         cur_q <= 3'h0;
         last_q <= 16'h0000;
      end
      else if (we_seq)
      begin
         seq_q <= wd[7:0];
         rep_q <= wd[SEQ_REP_POS];
         temp_q <= wd[SEQ_TEMP_POS];
         active_q <= first_new[3];
         cur_q <= first_new[2:0];
      end
      else if (convert)
      begin
         last_q <= adc_word;
         if (next_old[3])
            cur_q <= next_old[2:0];
         else if (rep_q)
            cur_q <= first_old[2:0];
         else
            active_q <= 1'b0;
      end
   end

   assign adc_channel = cur_q;

   // ----------------------------------------
   // GPIO configuration and pins
   // ----------------------------------------
   logic [7:0] ocfg_q, odat_q, icfg_q, od_q, ts_q, pd_q;
   logic [7:0] io_out_q, io_oe_q, io_pd_q;

   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
      begin
         ocfg_q <= CFG_RST;
         odat_q <= CFG_RST;
         icfg_q <= CFG_RST;
         od_q <= CFG_RST;
         ts_q <= CFG_RST;
         pd_q <= PULLDOWN_RST;
         io_out_q <= 8'h00;
         io_oe_q <= 8'h00;
         io_pd_q <= 8'h00;
      end
      else
      begin
         if (we_ocfg)
            ocfg_q <= wd[7:0];
         if (we_odat)
            odat_q <= (wd[7:0] & ocfg_q) | (odat_q & ~ocfg_q);
         if (we_icfg)
            icfg_q <= wd[7:0];
         if (we_od)
            od_q <= wd[7:0];
         if (we_ts)
            ts_q <= wd[7:0];
         if (we_pd)
            pd_q <= wd[7:0];
         io_out_q <= odat_q & ~od_q;
         io_oe_q <= ocfg_q & ~ts_q & ~(od_q & odat_q);
         io_pd_q <= pd_q & ~ts_q;
      end
   end

   assign io_out = io_out_q;
   assign io_oe = io_oe_q;
   assign io_pulldown = io_pd_q;

   // ----------------------------------------
   // Readback word
   // ----------------------------------------
   wire [15:0] dac_word = {RB_DAC_FLAG, dac_ch, dac_in_q[dac_ch]};
   wire [15:0] gpio_word = {8'h00, gpio_in_s & icfg_q};
   wire [15:0] adc_out = active_q ? adc_word : last_q;
   wire [15:0] rb_word = adc_rd ? adc_out :
      mode == MODE_DAC_RD ? dac_word :
      mode == MODE_GPIO_RD ? gpio_word : 16'h0000;

   always_ff @(posedge link.scl)
   begin
      if (!rst_n)
         tx_q <= 16'h0000;
      else if (load_tx)
         tx_q <= rb_word;
      else if (in_frame && rd_q && data_slot && byte_q != BYTE_CTRL)
         tx_q <= {tx_q[14:0], 1'b0};
   end
endmodule

// ---- design/icc_pkg.sv ----
// Shared constants for the I/O channel converter control link.
// Assumes both ends compile against this package first.
package icc_pkg;
   // ----------------------------------------
   // Channels and data
   // ----------------------------------------
   localparam int CH_N = 8;
   localparam int DAC_W = 12;
   localparam int SEQ_TEMP_POS = 8;
   localparam int SEQ_REP_POS = 9;
   localparam logic RB_DAC_FLAG = 1'b1;
   localparam logic RB_ADC_FLAG = 1'b0;
   // ----------------------------------------
   // Pointer modes and control registers
   // ----------------------------------------
   localparam logic [3:0] MODE_CFG = 4'h0;
   localparam logic [3:0] MODE_DAC_WR = 4'h1;
   localparam logic [3:0] MODE_ADC_RD = 4'h4;
   localparam logic [3:0] MODE_DAC_RD = 4'h5;
   localparam logic [3:0] MODE_GPIO_RD = 4'h6;
   localparam logic [3:0] REG_ADC_SEQ = 4'h2;
   localparam logic [3:0] REG_PULLDOWN = 4'h6;
   localparam logic [3:0] REG_LOAD_MODE = 4'h7;
   localparam logic [3:0] REG_GPIO_OUT_CFG = 4'h8;
   localparam logic [3:0] REG_GPIO_OUT_DATA = 4'h9;
   localparam logic [3:0] REG_GPIO_IN_CFG = 4'ha;
   localparam logic [3:0] REG_OPEN_DRAIN = 4'hc;
   localparam logic [3:0] REG_THREE_STATE = 4'hd;
   localparam logic [1:0] LOAD_AUTO = 2'h0;
   localparam logic [1:0] LOAD_HOLD = 2'h1;
   localparam logic [1:0] LOAD_PULSE = 2'h2;
   localparam logic [1:0] LOAD_RST = 2'h0;
   localparam logic [7:0] PULLDOWN_RST = 8'hff;
   localparam logic [7:0] CFG_RST = 8'h00;
   // ----------------------------------------
   // Framing
   // ----------------------------------------
   localparam logic [7:0] CTRL_WRITE = 8'h00;
   localparam logic [7:0] CTRL_READ = 8'h01;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [2:0] BYTE_CTRL = 3'h0;
   localparam logic [2:0] BYTE_PTR = 3'h1;
   localparam logic [2:0] BYTE_LSB = 3'h3;
   localparam logic [2:0] BYTE_SAT = 3'h4;
   localparam logic [2:0] LEN_WRITE = 3'h4;
   localparam logic [2:0] LEN_POINTER = 3'h2;
   localparam logic [2:0] LEN_READ = 3'h3;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCL_PERIOD_NS = 1000;
   localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_PERIOD_NS / (2 * CLK_PERIOD_NS));
   typedef enum logic [1:0] {CMD_WRITE = 2'b00, CMD_POINTER = 2'b01,
      CMD_READ = 2'b10} icc_cmd_e;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_RUN = 2'b10,
      H_END = 2'b11} icc_host_state_e;
endpackage

// ---- design/icc_link_if.sv ----
// Two-wire link between host and converter, plus a frame strobe.
// Assumes a pull-up on the data line; both ends only pull low.
`timescale 1ns/10ps
interface icc_link_if;
   logic scl;
   logic frame_n;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   wire sda_line;
   // Open-drain wired level
   assign sda_line = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
   modport host (output scl, output frame_n, output host_sda_out, output host_sda_oe,
      input sda_line);
   modport dev (input scl, input frame_n, output dev_sda_out, output dev_sda_oe,
      input sda_line);
endinterface

// ---- design/icc_host.sv ----
// Host end: makes scl, frames commands into link bytes.
// Assumes one command at a time from the user side.
`timescale 1ns/10ps
module icc_host
   import icc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   icc_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [7:0] cmd_pointer,
   input wire logic [15:0] cmd_data,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_nack
);
   // ----------------------------------------
   // Clock divider
   // ----------------------------------------
   logic [7:0] div_q;
   logic scl_q;
   wire tick = div_q == SCL_HALF_CYC - 8'h01;
   wire fall = tick && scl_q;
   wire rise = tick && !scl_q;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         div_q <= 8'h00;
         scl_q <= 1'b1;
      end
      else
      begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         if (tick)
            scl_q <= !scl_q;
      end
   end

   // ----------------------------------------
   // Data line synchroniser
   // ----------------------------------------
   logic sda_s1_q, sda_s2_q, sda_s3_q, sda_q;

   always_ff @(posedge clk_sys)
   begin
      sda_s1_q <= link.sda_line;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (!rstn)
         sda_q <= 1'b1;
      else if (sda_s2_q == sda_s3_q)
         sda_q <= sda_s2_q;
   end

   // ----------------------------------------
   // Frame engine
   // ----------------------------------------
   icc_host_state_e state_q;
   logic [31:0] txb_q;
   logic [2:0] len_q, byte_q;
   logic [3:0] bit_q;
   logic rd_q, frame_n_q, oe_q, rsp_q, nack_q;
   logic [15:0] rx_q;

   wire host_tx = !rd_q || byte_q == BYTE_CTRL;
   wire data_slot = bit_q < ACK_SLOT;
   wire last_byte = byte_q + 3'h1 == len_q;
   wire is_read = cmd_kind == CMD_READ;
   wire [2:0] cmd_len = is_read ? LEN_READ : cmd_kind == CMD_POINTER ? LEN_POINTER : LEN_WRITE;
   wire [7:0] cmd_ctrl = is_read ? CTRL_READ : CTRL_WRITE;
   wire slot_oe = data_slot ? (host_tx && !txb_q[31]) : (!host_tx && byte_q == BYTE_PTR);

   assign cmd_ready = state_q == H_IDLE;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         state_q <= H_IDLE;
         txb_q <= 32'h00000000;
         len_q <= 3'h0;
         byte_q <= 3'h0;
         bit_q <= 4'h0;
         rd_q <= 1'b0;
         frame_n_q <= 1'b1;
         oe_q <= 1'b0;
         rsp_q <= 1'b0;
         nack_q <= 1'b0;
         rx_q <= 16'h0000;
      end
      else
      begin
         rsp_q <= 1'b0;
         case (state_q)
            H_IDLE:
               if (cmd_valid)
               begin
                  txb_q <= {cmd_ctrl, cmd_pointer, cmd_data};
                  len_q <= cmd_len;
                  rd_q <= is_read;
                  state_q <= H_START;
               end
            H_START:
               if (fall)
               begin
                  frame_n_q <= 1'b0;
                  byte_q <= 3'h0;
                  bit_q <= 4'h0;
                  nack_q <= 1'b0;
                  oe_q <= !txb_q[31];
                  state_q <= H_RUN;
               end
            H_RUN:
               if (rise)
               begin
                  if (data_slot && host_tx)
                     txb_q <= {txb_q[30:0], 1'b0};
                  if (data_slot && !host_tx)
                     rx_q <= {rx_q[14:0], sda_q};
                  if (!data_slot && host_tx)
                     nack_q <= nack_q || sda_q;
                  if (data_slot)
                     bit_q <= bit_q + 4'h1;
                  else
                  begin
                     bit_q <= 4'h0;
                     byte_q <= byte_q + 3'h1;
                     if (last_byte)
                        state_q <= H_END;
                  end
               end
               else if (fall)
                  oe_q <= slot_oe;
            H_END:
               if (fall)
               begin
                  frame_n_q <= 1'b1;
                  oe_q <= 1'b0;
                  rsp_q <= 1'b1;
                  state_q <= H_IDLE;
               end
            default:
               state_q <= H_IDLE;
         endcase
      end
   end

   assign link.scl = scl_q;
   assign link.frame_n = frame_n_q;
   assign link.host_sda_out = 1'b0;
   assign link.host_sda_oe = oe_q;
   assign rsp_valid = rsp_q;
   assign rsp_data = rx_q;
   assign rsp_nack = nack_q;
endmodule

// ---- sim/icc_link_properties.sv ----
// Link checker: framing, acknowledge slots and read word layout.
// Assumes it watches the interface joining the two design ends.
`timescale 1ns/10ps
module icc_link_properties
   import icc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic scl,
   input wire logic frame_n,
   input wire logic host_sda_out,
   input wire logic host_sda_oe,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe,
   input wire logic sda_line
);
   // ----------------------------------------
   // Slot and byte tracking
   // ----------------------------------------
   logic [3:0] slot_q;
   logic [2:0] byte_q;
   logic [7:0] sh_q;
   logic [7:0] ptr_q;
   logic rd_q;
   wire at_ack = !frame_n && slot_q == ACK_SLOT;
   wire in_data = !frame_n && slot_q != ACK_SLOT;
   wire [3:0] slot_d = (frame_n || at_ack) ? 4'h0 : slot_q + 4'h1;
   wire [2:0] byte_d = frame_n ? 3'h0 : (at_ack ? byte_q + 3'h1 : byte_q);
   wire [7:0] sh_d = {sh_q[6:0], sda_line};
   wire byte_end = in_data && slot_q == LAST_BIT;
   wire rd_word = rd_q && !frame_n && byte_q == 3'h1;
   wire [3:0] mode = ptr_q[7:4];

   always_ff @(posedge scl)
   begin
      if (!rstn)
      begin
         slot_q <= 4'h0;
         byte_q <= 3'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         rd_q <= 1'b0;
      end
      else
      begin
         slot_q <= slot_d;
         byte_q <= byte_d;
         sh_q <= sh_d;
         if (byte_end && byte_q == BYTE_CTRL)
            rd_q <= (sh_d == CTRL_READ);
         if (byte_end && byte_q == BYTE_PTR && !rd_q)
            ptr_q <= sh_d;
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_dev_ack;
      @(posedge scl) disable iff (!rstn)
      at_ack && (byte_q == BYTE_CTRL || (!rd_q && byte_q <= BYTE_LSB)) |-> dev_sda_oe && !sda_line;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("device missed an acknowledge");

   property p_host_ack;
      @(posedge scl) disable iff (!rstn)
      rd_word && at_ack |-> host_sda_oe ##9 (!host_sda_oe && !dev_sda_oe && sda_line);
   endproperty
   a_host_ack: assert property (p_host_ack) else $error("read word ack pattern wrong");

   property p_dac_word;
      @(posedge scl) disable iff (!rstn)
      rd_word && slot_q == 4'h0 && mode == MODE_DAC_RD
         |-> sda_line ##1 sda_line == ptr_q[2] ##1 sda_line == ptr_q[1] ##1 sda_line == ptr_q[0];
   endproperty
   a_dac_word: assert property (p_dac_word) else $error("dac readback header wrong");

   property p_adc_flag;
      @(posedge scl) disable iff (!rstn)
      rd_word && slot_q == 4'h0 && mode == MODE_ADC_RD |-> !sda_line;
   endproperty
   a_adc_flag: assert property (p_adc_flag) else $error("adc word flag set");

   property p_gpio_upper;
      @(posedge scl) disable iff (!rstn)
      rd_word && in_data && mode == MODE_GPIO_RD |-> !sda_line;
   endproperty
   a_gpio_upper: assert property (p_gpio_upper) else $error("gpio upper byte not zero");

   property p_dev_idle;
      @(posedge scl) disable iff (!rstn)
      frame_n |-> !dev_sda_oe;
   endproperty
   a_dev_idle: assert property (p_dev_idle) else $error("device drives outside frame");

   property p_sda_stable;
      @(posedge clk_sys) disable iff (!rstn)
      scl && $past(scl) |-> $stable(sda_line);
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved while clock high");

   property p_frame_edge;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(frame_n) |-> !scl;
   endproperty
   a_frame_edge: assert property (p_frame_edge) else $error("frame edge with clock high");

   c_write: cover property (@(posedge scl) at_ack && !rd_q && byte_q == BYTE_LSB);
   c_dac_rd: cover property (@(posedge scl) rd_word && slot_q == 4'h0 && mode == MODE_DAC_RD);
   c_adc_rd: cover property (@(posedge scl) rd_word && slot_q == 4'h0 && mode == MODE_ADC_RD);
endmodule

// ---- sim/io_channel_converter_control_tb_top.sv ----
// Testbench: host and converter ends joined over the link interface.
// Assumes the host makes the link clock from clk_sys.
`timescale 1ns/10ps
module io_channel_converter_control_tb_top
   import icc_pkg::*;
   ;
   logic clk_sys, rstn, dev_rstn, cmd_valid, cmd_ready, rsp_valid, rsp_nack;
   logic [1:0] cmd_kind;
   logic [7:0] cmd_pointer, io_ext, io_out, io_oe, io_pulldown;
   logic [15:0] cmd_data, rsp_data;
   logic [95:0] dac_value;
   logic [11:0] adc_sample;
   logic [2:0] adc_channel;
   int err_total, check_count;
   logic [2:0] seq_a [4] = '{3'h0, 3'h2, 3'h7, 3'h7};
   logic [2:0] seq_b [3] = '{3'h1, 3'h7, 3'h1};
   // Driven pins show their own level, others the outside pattern
   wire [7:0] io_pad = (io_oe & io_out) | (~io_oe & io_ext);
   assign adc_sample = {adc_channel, 9'h05a};

   icc_link_if icc_link_if_inst();
   icc_host icc_host_inst (.clk_sys(clk_sys), .rstn(rstn), .link(icc_link_if_inst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_pointer(cmd_pointer), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   icc_device icc_device_inst (.rstn(dev_rstn), .link(icc_link_if_inst), .io_in(io_pad),
      .io_out(io_out), .io_oe(io_oe), .io_pulldown(io_pulldown), .dac_value(dac_value),
      .adc_sample(adc_sample), .adc_channel(adc_channel));
   icc_link_properties icc_link_properties_inst (.clk_sys(clk_sys), .rstn(dev_rstn),
      .scl(icc_link_if_inst.scl), .frame_n(icc_link_if_inst.frame_n),
      .host_sda_out(icc_link_if_inst.host_sda_out), .host_sda_oe(icc_link_if_inst.host_sda_oe),
      .dev_sda_out(icc_link_if_inst.dev_sda_out), .dev_sda_oe(icc_link_if_inst.dev_sda_oe),
      .sda_line(icc_link_if_inst.sda_line));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic xfer(input logic [1:0] k, input logic [7:0] p, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      cmd_kind = k;
      cmd_pointer = p;
      cmd_data = d;
      cmd_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 5000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 5000)
      begin
         err_total++;
         close_out();
      end
      check({15'h0000, rsp_nack}, 16'h0000);
   endtask

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      xfer(CMD_WRITE, p, d);
   endtask

   task automatic ptr(input logic [7:0] p);
      xfer(CMD_POINTER, p, 16'h0000);
   endtask

   task automatic rd;
      xfer(CMD_READ, 8'h00, 16'h0000);
   endtask

   function automatic logic [15:0] adc_word(input logic [2:0] ch);
      return {1'b0, ch, ch, 9'h05a};
   endfunction

   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      close_out();
   end

   initial
   begin
      rstn = 1'b0;
      dev_rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = 2'h0;
      cmd_pointer = 8'h00;
      cmd_data = 16'h0000;
      io_ext = 8'h5a;
      err_total = 0;
      check_count = 0;
      repeat (16) @(posedge clk_sys);
      #1 rstn = 1'b1;
      // Converter reset spans several link clock edges
      repeat (500) @(posedge clk_sys);
      #1 dev_rstn = 1'b1;
      repeat (500) @(posedge clk_sys);
      check(16'(io_pulldown), 16'h00ff);
      wr(8'h11, 16'h0123);
      check(16'(dac_value[23:12]), 16'h0123);
      wr(8'h07, 16'h0001);
      wr(8'h12, 16'h0abc);
      check(16'(dac_value[35:24]), 16'h0000);
      wr(8'h07, 16'h0002);
      check(16'(dac_value[35:24]), 16'h0abc);
      wr(8'h13, 16'h0555);
      check(16'(dac_value[47:36]), 16'h0000);
      ptr(8'h52);
      rd();
      check(rsp_data, 16'haabc);
      wr(8'h04, 16'h0085);
      wr(8'h02, 16'h0085);
      check(16'(adc_channel), 16'h0000);
      ptr(8'h40);
      foreach (seq_a[i])
      begin
         rd();
         check(rsp_data, adc_word(seq_a[i]));
      end
      wr(8'h02, 16'h0282);
      check(16'(adc_channel), 16'h0001);
      ptr(8'h40);
      foreach (seq_b[i])
      begin
         rd();
         check(rsp_data, adc_word(seq_b[i]));
      end
      // Cleared sequence: no further conversion, last word held
      wr(8'h02, 16'h0000);
      ptr(8'h40);
      rd();
      check(rsp_data, adc_word(3'h1));
      wr(8'h08, 16'h001f);
      wr(8'h0c, 16'h0002);
      wr(8'h09, 16'h00f3);
      check(16'(io_out), 16'h0011);
      check(16'(io_oe), 16'h001d);
      wr(8'h0d, 16'h0001);
      check(16'(io_oe), 16'h001c);
      check(16'(io_pulldown), 16'h00fe);
      wr(8'h0a, 16'h00c0);
      ptr(8'h60);
      rd();
      check(rsp_data, 16'h0040);
      close_out();
   end
endmodule
